// >>> rtl/ten_bit_framed_serializer.sv
/*
 * Framed ten-bit serializer with lock, sync burst and data phases, plus
 * an AXI4-Lite register slave.
 * Assumes core_clk is the serial bit clock and that the reference strobe
 * clock is synchronous to it with a period of twelve core_clk cycles.
 */
`timescale 1ns/1ns
`include "serializer_consts.svh"

// Function
// - Frame word with high start, low stop
// - Twelve bits sent per reference period
// - Phases: init, then sync, then data
// - Output off, logic held during reset
// - Lock within 2049 reference cycles
// - Output off while acquiring lock
// - Sync inputs choose sync or data frames
// - Sync pattern: six ones, six zeros
// - Six high cycles start 1024-pattern burst
// - Keep syncing while a request stays high
// - Burst runs to end regardless of toggles
// - Latch word each period when syncs low
// - Edge select picks rising or falling capture
// - Sync during data ignores word inputs
// - Power-down stops lock, output off
// - Power-up reruns lock then sync
// - Enable low or power-down forces off
// - Enable gates drivers only, not timing

module ten_bit_framed_serializer #(
   parameter int LOCK_CYCLES = `LOCK_CYCLES_DEF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Reference strobe and parallel data
   input wire logic reference_strobe_clock,
   input wire logic strobe_edge_select,
   input wire logic [9:0] parallel_word_in,
   // Control pins
   input wire logic sync_req_a,
   input wire logic sync_req_b,
   input wire logic power_down_n,
   input wire logic output_enable,
   // Serial output pair, driven only while enabled
   output logic serial_out_p,
   output logic serial_out_n,
   output logic serial_oe,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // -------------------------------------------------------------------
   // Reference edges and reset
   // -------------------------------------------------------------------
   // Power-down acts as a reset of the whole datapath so lock restarts.
   logic hold_rst;
   logic ref_q_r;
   logic ref_rise;
   logic ref_fall;
   logic cap_edge;
   logic sync_or;
   logic frame_load;
   logic trigger;
   logic send_sync;
   logic [11:0] frame_word;
   serializer_pkg::phase_e phase_r;
   logic [11:0] lock_cnt_r;
   logic [2:0] sync_hi_cnt_r;
   logic [10:0] burst_cnt_r;
   logic [9:0] data_latch_r;
   logic [11:0] shift_r;
   logic [31:0] ctrl_r;

   assign hold_rst = rst | ~power_down_n;
   assign sync_or = sync_req_a | sync_req_b;
   assign ref_rise = reference_strobe_clock & ~ref_q_r;
   assign ref_fall = ~reference_strobe_clock & ref_q_r;
   assign cap_edge = strobe_edge_select ? ref_rise : ref_fall;
   assign frame_load = ref_rise && (phase_r != serializer_pkg::ST_INIT);
   assign trigger = frame_load && sync_or && burst_cnt_r == 11'h000
                    && sync_hi_cnt_r == `SYNC_HOLD_CYCLES - 3'h1;
   assign send_sync = (phase_r == serializer_pkg::ST_SYNC) || trigger;
   assign frame_word = send_sync ? `SYNC_PATTERN :
                       {`STOP_BIT, data_latch_r, `START_BIT};

   // Tracking the pin through reset keeps a high level at release from reading as a rise.
   always_ff @(posedge core_clk) begin
      ref_q_r <= reference_strobe_clock;
   end

   // -------------------------------------------------------------------
   // Lock counter and phase sequence
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (hold_rst) begin
         lock_cnt_r <= 12'h000;
      end else if (phase_r == serializer_pkg::ST_INIT && ref_rise) begin
         lock_cnt_r <= lock_cnt_r + 12'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (hold_rst) begin
         phase_r <= serializer_pkg::ST_INIT;
      end else begin
         case (phase_r)
            serializer_pkg::ST_INIT: begin
               if (ref_rise && lock_cnt_r == 12'(LOCK_CYCLES - 1)) begin
                  phase_r <= serializer_pkg::ST_SYNC;
               end
            end
            serializer_pkg::ST_SYNC: begin
               // Leaving needs the burst spent and both requests low.
               if (frame_load && burst_cnt_r <= 11'h001 && !sync_or) begin
                  phase_r <= serializer_pkg::ST_DATA;
               end
            end
            serializer_pkg::ST_DATA: begin
               if (trigger) begin
                  phase_r <= serializer_pkg::ST_SYNC;
               end
            end
            default: begin
               phase_r <= serializer_pkg::ST_INIT;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Sync request qualification and burst count
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (hold_rst || !sync_or) begin
         sync_hi_cnt_r <= 3'h0;
      end else if (frame_load && sync_hi_cnt_r != `SYNC_HOLD_CYCLES) begin
         sync_hi_cnt_r <= sync_hi_cnt_r + 3'h1;
      end
   end

   // The pattern sent in the trigger frame is the first of the burst.
   always_ff @(posedge core_clk) begin
      if (hold_rst) begin
         burst_cnt_r <= 11'h000;
      end else if (trigger) begin
         burst_cnt_r <= `BURST_LEN - 11'h001;
      end else if (frame_load && burst_cnt_r != 11'h000) begin
         burst_cnt_r <= burst_cnt_r - 11'h001;
      end
   end

   // -------------------------------------------------------------------
   // Input latch and shifter
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (hold_rst) begin
         data_latch_r <= 10'h000;
      end else if (cap_edge && !sync_or) begin
         data_latch_r <= parallel_word_in;
      end
   end

   // A slow reference pads the frame with stop-level bits.
   always_ff @(posedge core_clk) begin
      if (hold_rst) begin
         shift_r <= 12'h000;
      end else if (frame_load) begin
         shift_r <= frame_word;
      end else begin
         shift_r <= {1'b0, shift_r[11:1]};
      end
   end

   assign serial_out_p = shift_r[0];
   assign serial_out_n = ~shift_r[0];
   // Enable reaches the drivers combinationally and touches no state.
   assign serial_oe = output_enable && power_down_n && ctrl_r[`CTRL_DRIVE_BIT]
                      && phase_r != serializer_pkg::ST_INIT;

   // -------------------------------------------------------------------
   // AXI4-Lite slave
   // -------------------------------------------------------------------
   function automatic serializer_pkg::reg_sel_e decode(input logic [7:0] addr);
      if (addr == `REG_CTRL) begin
         decode = serializer_pkg::SEL_CTRL;
      end else if (addr == `REG_STATUS) begin
         decode = serializer_pkg::SEL_STATUS;
      end else if (addr == `REG_BURST) begin
         decode = serializer_pkg::SEL_BURST;
      end else begin
         decode = serializer_pkg::SEL_NONE;
      end
   endfunction : decode

   logic aw_held_r;
   logic w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic do_write;
   serializer_pkg::status_s status;

   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

   // Fields from the top: pad, sync_req, bursting, drive_on, phase.
   assign status = {27'h000_0000, sync_or, burst_cnt_r != 11'h000, serial_oe, phase_r};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_r <= `CTRL_RESET;
      end else if (do_write && decode(awaddr_r) == serializer_pkg::SEL_CTRL
                   && wstrb_r[0]) begin
         ctrl_r <= {31'h0000_0000, wdata_r[`CTRL_DRIVE_BIT]};
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= decode(awaddr_r) == serializer_pkg::SEL_NONE ?
                        `RESP_DECERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         if (decode(s_axi_araddr) == serializer_pkg::SEL_CTRL) begin
            s_axi_rdata <= ctrl_r;
         end else if (decode(s_axi_araddr) == serializer_pkg::SEL_STATUS) begin
            s_axi_rdata <= status;
         end else if (decode(s_axi_araddr) == serializer_pkg::SEL_BURST) begin
            s_axi_rdata <= {21'h00_0000, burst_cnt_r};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_DECERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (hold_rst);

   sequence s_lock_done;
      phase_r == serializer_pkg::ST_INIT && ref_rise
         && lock_cnt_r == 12'(LOCK_CYCLES - 1);
   endsequence

   sequence s_data_frame;
      frame_load && !send_sync;
   endsequence

   property p_data_framing;
      s_data_frame |=> shift_r[0] == `START_BIT && shift_r[11] == `STOP_BIT
         && shift_r[10:1] == $past(data_latch_r);
   endproperty
   a_data_framing: assert property (p_data_framing) else $error("bad data frame");

   property p_sync_pattern;
      frame_load && send_sync |=> shift_r == `SYNC_PATTERN;
   endproperty
   a_sync_pattern: assert property (p_sync_pattern) else $error("bad sync pattern");

   property p_lock_off;
      phase_r == serializer_pkg::ST_INIT |-> !serial_oe;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("driving during lock");

   property p_lock_exit;
      s_lock_done |=> phase_r == serializer_pkg::ST_SYNC;
   endproperty
   a_lock_exit: assert property (p_lock_exit) else $error("lock did not finish");

   property p_enable_off;
      !output_enable |-> !serial_oe;
   endproperty
   a_enable_off: assert property (p_enable_off) else $error("enable low but driving");

   property p_burst_start;
      trigger |=> burst_cnt_r == `BURST_LEN - 11'h001
         && phase_r == serializer_pkg::ST_SYNC;
   endproperty
   a_burst_start: assert property (p_burst_start) else $error("burst not started");

   property p_burst_holds;
      burst_cnt_r != 11'h000 |-> phase_r == serializer_pkg::ST_SYNC;
   endproperty
   a_burst_holds: assert property (p_burst_holds) else $error("burst interrupted");

   property p_sync_persist;
      frame_load && phase_r == serializer_pkg::ST_SYNC && sync_or
         |=> phase_r == serializer_pkg::ST_SYNC;
   endproperty
   a_sync_persist: assert property (p_sync_persist) else $error("left sync early");

   property p_capture;
      cap_edge && !sync_or |=> data_latch_r == $past(parallel_word_in);
   endproperty
   a_capture: assert property (p_capture) else $error("word not latched");

   property p_shift;
      !frame_load ##1 !frame_load |-> shift_r[10:0] == $past(shift_r[11:1]);
   endproperty
   a_shift: assert property (p_shift) else $error("shifter stalled");

endmodule : ten_bit_framed_serializer

// >>> rtl/serializer_consts.svh
/*
 * Constants for the framed ten-bit serializer: register offsets, field
 * positions, reset values, frame patterns and counts.
 * Assumes inclusion by bare name from the serializer package user files.
 */
`ifndef SERIALIZER_CONSTS_SVH
`define SERIALIZER_CONSTS_SVH

// ----------------------------------------------------------------------
// Frame shape
// ----------------------------------------------------------------------
`define WORD_BITS 10
`define FRAME_BITS 12
`define START_BIT 1'b1
`define STOP_BIT 1'b0
`define SYNC_PATTERN 12'h03F
`define SYNC_HOLD_CYCLES 3'h6
`define BURST_LEN 11'h400
`define LOCK_CYCLES_DEF 2049

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_BURST 8'h08
`define CTRL_DRIVE_BIT 0
`define CTRL_RESET 32'h0000_0001
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// >>> rtl/serializer_pkg.sv
/*
 * Types for the framed ten-bit serializer.
 * Assumes the constants header is available on the include path.
 */
package serializer_pkg;

   typedef enum logic [1:0] {
      ST_INIT,
      ST_SYNC,
      ST_DATA
   } phase_e;

   typedef enum logic [1:0] {
      SEL_CTRL,
      SEL_STATUS,
      SEL_BURST,
      SEL_NONE
   } reg_sel_e;

   // Status word as software reads it.
   typedef struct packed {
      logic [26:0] pad;
      logic sync_req;
      logic bursting;
      logic drive_on;
      logic [1:0] phase;
   } status_s;

endpackage : serializer_pkg

// >>> sim/frame_receiver.sv
/* Behavioural deserializer: recovers 12-bit frames from the serial pair.
   Requests sync until it has seen enough sync patterns since the line last went quiet.
   Assumes a frame starts one cycle after a sampled reference rise. */
`timescale 1ns/1ns
module frame_receiver (
   // Clock and reference
   input wire logic core_clk,
   input wire logic reference_strobe_clock,
   // Serial pair
   input wire logic serial_out_p,
   input wire logic serial_out_n,
   input wire logic serial_oe,
   // Recovered frames and sync request
   output logic [11:0] rx_frame,
   output int rx_frames,
   output int sync_run,
   output int last_run,
   output int pol_errs,
   output logic rx_sync_req
);
   // ------------------------------------------------------------
   // Frame recovery
   // ------------------------------------------------------------
   localparam int LOCK_PATTERNS = 8;
   logic [11:0] bits = 0;
   logic line = 0;
   logic ref_q = 0;
   logic req = 1;
   int pos = 0;
   int good = 0;
   initial begin
      rx_frame = 0;
      rx_frames = 0;
      sync_run = 0;
      last_run = 0;
      pol_errs = 0;
      rx_sync_req = 1;
   end
   always @(posedge core_clk) begin
      // An undriven pair reads as the inverse of its last level.
      line = serial_oe ? serial_out_p : ~line;
      if (serial_oe && serial_out_n !== ~serial_out_p) begin
         pol_errs++;
      end
      if (!serial_oe) begin
         // Lock is lost whenever the line goes quiet.
         good = 0;
         req = 1;
      end
      if (pos > 0) begin
         bits[pos - 1] = line;
         pos++;
      end
      if (pos == 13) begin
         rx_frame = bits;
         rx_frames++;
         if (bits == 12'h03F) begin
            sync_run++;
            good++;
         end else begin
            last_run = (sync_run > 0) ? sync_run : last_run;
            sync_run = 0;
         end
         if (good >= LOCK_PATTERNS) begin
            req = 0;
         end
         pos = 0;
      end
      if (reference_strobe_clock && !ref_q) begin
         pos = 1;
      end
      ref_q = reference_strobe_clock;
      rx_sync_req <= req;
   end
endmodule : frame_receiver

// >>> sim/ten_bit_framed_serializer_tb.sv
/* Self-checking bench for the framed serializer and its register slave.
   Assumes the receiver model drives the second sync request. */
`timescale 1ns/1ns
`include "serializer_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %0t value %0h expected %0h", $time, (g), (e)); end end
module ten_bit_framed_serializer_tb;
   // ------------------------------------------------------------
   // Stimulus and wiring
   // ------------------------------------------------------------
   localparam int LOCK = 4;
   localparam logic [9:0] WORDS [5] = '{10'h000, 10'h3FF, 10'h2AA, 10'h155, 10'h201};
   logic core_clk = 0;
   logic rst = 1;
   logic reference_strobe_clock = 0;
   logic [3:0] ref_cnt = 0;
   logic strobe_edge_select = 1;
   logic [9:0] parallel_word_in = 0;
   logic sync_req_a = 0;
   logic sync_req_b;
   logic power_down_n = 0;
   logic output_enable = 1;
   logic serial_out_p, serial_out_n, serial_oe;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] d;
   logic [11:0] rx_frame;
   int rx_frames, sync_run, last_run, pol_errs, b1;
   int fails = 0;
   int compares = 0;
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      ref_cnt <= (ref_cnt == 4'hB) ? 4'h0 : ref_cnt + 4'h1;
      reference_strobe_clock <= (ref_cnt < 4'h6);
   end
   ten_bit_framed_serializer #(.LOCK_CYCLES(LOCK)) DUT (.core_clk, .rst,
      .reference_strobe_clock, .strobe_edge_select, .parallel_word_in, .sync_req_a,
      .sync_req_b, .power_down_n, .output_enable, .serial_out_p, .serial_out_n,
      .serial_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   frame_receiver rx (.core_clk, .reference_strobe_clock, .serial_out_p,
      .serial_out_n, .serial_oe, .rx_frame, .rx_frames, .sync_run, .last_run,
      .pol_errs, .rx_sync_req(sync_req_b));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [11:0] fr(input logic [9:0] w);
      return {1'b0, w, 1'b1};
   endfunction : fr
   task complete_run();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ad, wd;
      @(posedge core_clk);
      ad = 1;
      wd = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (ad || wd) begin
         @(negedge core_clk);
         ad = ad && !s_axi_awready;
         wd = wd && !s_axi_wready;
         @(posedge core_clk);
         s_axi_awvalid <= ad;
         s_axi_wvalid <= wd;
      end
      s_axi_bready <= 1;
      do begin
         @(negedge core_clk);
         rs = s_axi_bresp;
      end while (s_axi_bvalid !== 1'b1);
      @(posedge core_clk);
      s_axi_bready <= 0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ad;
      @(posedge core_clk);
      ad = 1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      while (ad) begin
         @(negedge core_clk);
         ad = !s_axi_arready;
         @(posedge core_clk);
         s_axi_arvalid <= ad;
      end
      s_axi_rready <= 1;
      do begin
         @(negedge core_clk);
         v = s_axi_rdata;
         rs = s_axi_rresp;
      end while (s_axi_rvalid !== 1'b1);
      @(posedge core_clk);
      s_axi_rready <= 0;
   endtask : rd
   // The pair must stay off for the first LOCK-1 reference periods of the lock count, then come up.
   task chk_lock();
      int i, bad;
      bad = 0;
      for (i = 0; i < (LOCK - 1) * 12; i++) begin
         @(negedge core_clk);
         bad += (serial_oe !== 1'b0);
      end
      `CHK(bad, 0)
      for (i = 0; i < 36 && serial_oe !== 1'b1; i++) @(negedge core_clk);
      `CHK(serial_oe, 1'b1)
      rd(`REG_STATUS, d, r);
      `CHK(d[1:0], serializer_pkg::ST_SYNC)
   endtask : chk_lock
   task wait_data();
      int i;
      for (i = 0; i < 20000 && sync_run == 0; i++) @(negedge core_clk);
      for (i = 0; i < 20000 && sync_run != 0; i++) @(negedge core_clk);
      `CHK(sync_run, 0)
   endtask : wait_data
   task t_lock();
      @(negedge core_clk);
      `CHK(serial_oe, 1'b0)
      @(posedge core_clk);
      rst <= 0;
      chk_lock();
      $display("lock test done");
   endtask : t_lock
   task t_burst();
      repeat (2400) @(posedge core_clk);
      sync_req_a <= 1;
      repeat (24) @(posedge core_clk);
      sync_req_a <= 0;
      wait_data();
      `CHK(last_run >= 1024 && last_run <= 1040, 1'b1)
      rd(`REG_STATUS, d, r);
      `CHK(d[1:0], serializer_pkg::ST_DATA)
      $display("burst test done");
   endtask : t_burst
   task t_data();
      int e, k, n0;
      for (e = 0; e < 2; e++) begin
         // One word stands while the reference is high, another while it is low.
         repeat (48) begin
            @(posedge core_clk);
            strobe_edge_select <= e[0];
            parallel_word_in <= reference_strobe_clock ? 10'h0F0 : 10'h30C;
         end
         @(negedge core_clk);
         `CHK(rx_frame, fr(e[0] ? 10'h30C : 10'h0F0))
         for (k = 0; k < 5; k++) begin
            @(posedge core_clk);
            strobe_edge_select <= e[0];
            parallel_word_in <= WORDS[k];
            @(negedge core_clk);
            n0 = rx_frames;
            repeat (36) @(negedge core_clk);
            `CHK(rx_frame, fr(WORDS[k]))
            `CHK(rx_frames - n0, 3)
         end
      end
      $display("data test done");
   endtask : t_data
   task t_hold();
      @(posedge core_clk);
      sync_req_a <= 1;
      parallel_word_in <= 10'h0F0;
      repeat (24) @(negedge core_clk);
      `CHK(rx_frame, fr(10'h201))
      @(posedge core_clk);
      sync_req_a <= 0;
      repeat (36) @(negedge core_clk);
      `CHK(rx_frame, fr(10'h0F0))
      $display("short request test done");
   endtask : t_hold
   task t_resync();
      @(posedge core_clk);
      sync_req_a <= 1;
      parallel_word_in <= 10'h3C3;
      repeat (96) @(negedge core_clk);
      `CHK(rx_frame, 12'h03F)
      @(posedge core_clk);
      sync_req_a <= 0;
      repeat (600) @(posedge core_clk);
      rd(`REG_BURST, d, r);
      b1 = d[10:0];
      @(posedge core_clk);
      output_enable <= 0;
      @(negedge core_clk);
      `CHK(serial_oe, 1'b0)
      repeat (24) @(posedge core_clk);
      output_enable <= 1;
      rd(`REG_BURST, d, r);
      `CHK((b1 - int'(d[10:0])) inside {[2:4]}, 1'b1)
      wait_data();
      `CHK(rx_frame, fr(10'h3C3))
      $display("resync test done");
   endtask : t_resync
   task t_power();
      @(posedge core_clk);
      power_down_n <= 0;
      @(negedge core_clk);
      `CHK(serial_oe, 1'b0)
      rd(`REG_STATUS, d, r);
      `CHK(d[1:0], serializer_pkg::ST_INIT)
      @(posedge core_clk);
      power_down_n <= 1;
      sync_req_a <= 1;
      chk_lock();
      repeat (14400) @(posedge core_clk);
      sync_req_a <= 0;
      wait_data();
      `CHK(last_run >= 1100, 1'b1)
      $display("power test done");
   endtask : t_power
   task t_regs();
      rd(`REG_CTRL, d, r);
      `CHK(d, `CTRL_RESET)
      `CHK(r, `RESP_OKAY)
      wr(8'h0C, 32'h0000_0001, r);
      `CHK(r, `RESP_DECERR)
      rd(8'h0C, d, r);
      `CHK(r, `RESP_DECERR)
      wr(`REG_CTRL, 32'h0000_0000, r);
      @(negedge core_clk);
      `CHK(serial_oe, 1'b0)
      rd(`REG_CTRL, d, r);
      `CHK(d[0], 1'b0)
      wr(`REG_CTRL, `CTRL_RESET, r);
      @(negedge core_clk);
      `CHK(serial_oe, 1'b1)
      `CHK(pol_errs, 0)
      $display("register test done");
   endtask : t_regs
   initial begin
      repeat (8) @(posedge core_clk);
      power_down_n <= 1;
      repeat (8) @(posedge core_clk);
      t_lock();
      t_burst();
      t_data();
      t_hold();
      t_resync();
      t_power();
      t_regs();
      complete_run();
   end
   // A hang costs at most about twice the expected run.
   initial begin
      repeat (90000) @(posedge core_clk);
      fails++;
      complete_run();
   end
endmodule : ten_bit_framed_serializer_tb
